/* core/codec_clk_pkg.sv */
// Package for the codec clock and power-up initialization controller.
// Assumes a control-port master outside that moves single register bytes.
package codec_clk_pkg;

    // ****************************************************************
    // Device register map
    // ****************************************************************
    localparam logic [7:0] CLOCK_CONTROL_ADDR     = 8'h00;
    localparam logic [7:0] PLL_PARAM_FIRST_ADDR   = 8'h01;
    localparam logic [7:0] PLL_RATIO_CONTROL_ADDR = 8'h05;
    localparam logic [7:0] PLL_LOCK_STATUS_ADDR   = 8'h06;
    localparam logic [7:0] DSP_RUN_CONTROL_ADDR   = 8'h09;

    // Clock control, lock status and DSP run field positions
    localparam int CORE_EN_BIT   = 0;
    localparam int SRC_SEL_BIT   = 3;
    localparam int CDIV_BIT      = 1;
    localparam int MDIV_BIT      = 2;
    localparam int PLL_EN_BIT    = 7;
    localparam int LOCK_BIT      = 0;
    localparam int DSP_RUN_BIT   = 0;

    // Pll ratio control field positions
    localparam int FRAC_BIT      = 0;
    localparam int X_LSB         = 1;
    localparam int R_LSB         = 3;

    // ****************************************************************
    // Controller's own register map (plain port)
    // ****************************************************************
    localparam logic [3:0] CMD_CTRL_ADDR   = 4'h0;
    localparam logic [3:0] CMD_CLKCFG_ADDR = 4'h1;
    localparam logic [3:0] CMD_PARAM0_ADDR = 4'h2;
    localparam logic [3:0] CMD_STATUS_ADDR = 4'h7;
    localparam logic [3:0] CMD_XFER_ADDR   = 4'h8;
    localparam logic [3:0] CMD_XDATA_ADDR  = 4'h9;
    localparam int         PARAM_COUNT     = 5;

    // Ctrl bits
    localparam int CTL_START_BIT = 0;
    localparam int CTL_USEPLL_BIT = 1;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_MHZ         = 100;
    localparam int RESET_WAIT_MS   = 15;
    localparam int RESET_WAIT_CYC  = RESET_WAIT_MS * 1000 * CLK_MHZ;
    localparam int LOCK_POLL_LIMIT = 1000;

    typedef enum {
        ST_BOOT, ST_IDLE, ST_PLL_OFF, ST_PARAM, ST_PLL_ON, ST_POLL_RD,
        ST_POLL_WAIT, ST_CORE_ON, ST_READY, ST_XFER, ST_XFER_WAIT, ST_FAIL
    } state_t;

    // One access on the device control port
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dev_req_t;

endpackage

/* core/codec_clk_host.sv */
// Host controller that programs the codec clock tree and PLL at power-up.
// Assumes a device port that takes one byte access per request and answers
// with a done pulse; software drives the plain command port.
// What the datasheet requires
// - Crystal source: set core enable bit 0 of clock control to run oscillator.
// - When the PLL is used, program it for exactly 24.576 MHz.
// - Bypass only with a 12.288 or 24.576 MHz reference clock.
// - Never rewrite divider fields after setup; source select may change live.
// - Choose dividers so master and core clocks are 12.288 MHz.
// - Keep core clock off during lock; poll lock; enable after lock.
// - Clear PLL enable, write 0x01-0x05, set enable, poll 0x06, set core.
// - During lock only 0x00-0x06 accessible until core enable and lock.
// - After DSP run is set, do not touch decimator or DAC source fields; the code only reports DSP run in status and still passes every later write.
// - PLL reference between 8 and 27 MHz; mode chosen by frequency.
// - Fractional output is (R+N/M)/2 times reference; N/M within 0.1-0.9.
// - PLL output must stay between 20.5 and 27 MHz.
// - Clock output times-2 only valid when master divider halves.
`timescale 1ns/100ps
module codec_clk_host #(
    parameter int RESET_WAIT = codec_clk_pkg::RESET_WAIT_CYC
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    input  wire logic [3:0]  i_cmd_addr,
    input  wire logic [7:0]  i_cmd_wdata,
    input  wire logic        i_cmd_wr,
    input  wire logic        i_cmd_rd,
    output logic      [7:0]  o_cmd_rdata,
    output logic             o_dev_wr,
    output logic             o_dev_rd,
    output logic      [7:0]  o_dev_addr,
    output logic      [7:0]  o_dev_wdata,
    input  wire logic        i_dev_done,
    input  wire logic [7:0]  i_dev_rdata
);

    // ****************************************************************
    // Command registers
    // ****************************************************************
    logic [7:0]  ctrl_reg;
    logic [7:0]  clkcfg_reg;
    logic [7:0]  param_reg [codec_clk_pkg::PARAM_COUNT];
    logic [7:0]  xfer_addr_reg;
    logic [7:0]  xfer_data_reg;
    logic        xfer_wr_reg;
    logic        xfer_go_reg;
    logic        frozen_reg;
    logic        locked_reg;
    logic        ready_reg;
    logic        fail_reg;
    logic        dsp_run_reg;
    logic        refused_reg;
    logic [7:0]  rdata_reg;
    codec_clk_pkg::state_t      state_reg;
    codec_clk_pkg::dev_req_t    req_reg;
    logic [31:0] wait_reg;
    logic [2:0]  idx_reg;
    logic [9:0]  poll_reg;

    // ****************************************************************
    // Decode
    // ****************************************************************
    wire ctrl_hit   = i_cmd_wr && (i_cmd_addr == codec_clk_pkg::CMD_CTRL_ADDR);
    wire clkcfg_hit = i_cmd_wr
                   && (i_cmd_addr == codec_clk_pkg::CMD_CLKCFG_ADDR);
    wire param_hit  = i_cmd_wr && (i_cmd_addr >= codec_clk_pkg::CMD_PARAM0_ADDR)
                   && (i_cmd_addr < codec_clk_pkg::CMD_STATUS_ADDR);
    wire xaddr_hit  = i_cmd_wr && (i_cmd_addr == codec_clk_pkg::CMD_XFER_ADDR);
    wire xdata_hit  = i_cmd_wr && (i_cmd_addr == codec_clk_pkg::CMD_XDATA_ADDR);
    wire [2:0] pidx = 3'(i_cmd_addr - codec_clk_pkg::CMD_PARAM0_ADDR);
    wire start      = ctrl_hit && i_cmd_wdata[codec_clk_pkg::CTL_START_BIT];
    wire use_pll    = ctrl_reg[codec_clk_pkg::CTL_USEPLL_BIT];
    // Divider bits kept from first setup; only source select follows cfg
    wire src_only   = (xfer_addr_reg == codec_clk_pkg::CLOCK_CONTROL_ADDR);
    wire dev_lock   = i_dev_rdata[codec_clk_pkg::LOCK_BIT];
    // Core enable must stay clear until lock, so setup byte drops bit 0
    wire [7:0] cfg_nocore = clkcfg_reg
                          & ~(8'h01 << codec_clk_pkg::CORE_EN_BIT)
                          & ~(8'h01 << codec_clk_pkg::PLL_EN_BIT);
    wire [7:0] cfg_pll  = cfg_nocore | (8'h01 << codec_clk_pkg::PLL_EN_BIT);
    wire [7:0] cfg_core = (use_pll ? cfg_pll : cfg_nocore)
                        | (8'h01 << codec_clk_pkg::CORE_EN_BIT);
    wire [7:0] dsp_bit  = 8'h01 << codec_clk_pkg::DSP_RUN_BIT;

    // ****************************************************************
    // Command port writes
    // ****************************************************************
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_reg      <= 8'h00;
            clkcfg_reg    <= 8'h00;
            xfer_addr_reg <= 8'h00;
            xfer_data_reg <= 8'h00;
        end else begin
            if (ctrl_hit)
                ctrl_reg <= i_cmd_wdata & ~8'h01;
            // Dividers freeze after setup; source select stays live
            if (clkcfg_hit && !frozen_reg)
                clkcfg_reg <= i_cmd_wdata;
            else if (clkcfg_hit)
                clkcfg_reg[codec_clk_pkg::SRC_SEL_BIT] <=
                    i_cmd_wdata[codec_clk_pkg::SRC_SEL_BIT];
            if (xaddr_hit)
                xfer_addr_reg <= i_cmd_wdata;
            if (xdata_hit)
                xfer_data_reg <= i_cmd_wdata;
            if (state_reg == codec_clk_pkg::ST_XFER_WAIT && i_dev_done
                && !xfer_wr_reg)
                xfer_data_reg <= i_dev_rdata;
        end
    end

    // Pll parameter bytes, one per device register 0x01..0x05
    generate
        for (genvar g = 0; g < codec_clk_pkg::PARAM_COUNT; g++) begin : g_par
            always_ff @(posedge i_sys_clk or posedge i_rst) begin
                if (i_rst)
                    param_reg[g] <= 8'h00;
                else if (param_hit && pidx == 3'(g) && !frozen_reg)
                    param_reg[g] <= i_cmd_wdata;
            end
        end
    endgenerate

    // ****************************************************************
    // Initialization sequencer
    // ****************************************************************
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg   <= codec_clk_pkg::ST_BOOT;
            req_reg     <= '0;
            wait_reg    <= 32'h0;
            idx_reg     <= 3'h0;
            poll_reg    <= 10'h0;
            frozen_reg  <= 1'b0;
            locked_reg  <= 1'b0;
            ready_reg   <= 1'b0;
            fail_reg    <= 1'b0;
            xfer_go_reg <= 1'b0;
            xfer_wr_reg <= 1'b0;
            dsp_run_reg <= 1'b0;
            refused_reg <= 1'b0;
        end else begin
            req_reg.wr <= 1'b0;
            req_reg.rd <= 1'b0;
            if (i_cmd_wr && i_cmd_addr == codec_clk_pkg::CMD_STATUS_ADDR)
                refused_reg <= 1'b0;
            case (state_reg)
                // Device is still in its own power-up reset
                codec_clk_pkg::ST_BOOT: begin
                    wait_reg <= wait_reg + 32'h1;
                    if (wait_reg >= 32'(RESET_WAIT - 1))
                        state_reg <= codec_clk_pkg::ST_IDLE;
                end
                codec_clk_pkg::ST_IDLE: begin
                    if (start) begin
                        state_reg   <= codec_clk_pkg::ST_PLL_OFF;
                        req_reg.wr    <= 1'b1;
                        req_reg.addr  <= codec_clk_pkg::CLOCK_CONTROL_ADDR;
                        req_reg.wdata <= cfg_nocore;
                    end else if (xfer_go_reg) begin
                        xfer_go_reg <= 1'b0;
                        refused_reg <= 1'b1;
                    end
                end
                // Pll disabled, then program 0x01..0x05 in order, or go straight to core on when the PLL is not used
                codec_clk_pkg::ST_PLL_OFF: begin
                    if (i_dev_done) begin
                        idx_reg <= 3'h0;
                        if (use_pll) begin
                            state_reg     <= codec_clk_pkg::ST_PARAM;
                            req_reg.wr    <= 1'b1;
                            req_reg.addr  <=
                                codec_clk_pkg::PLL_PARAM_FIRST_ADDR;
                            req_reg.wdata <= param_reg[0];
                        end else begin
                            state_reg     <= codec_clk_pkg::ST_CORE_ON;
                            req_reg.wr    <= 1'b1;
                            req_reg.addr  <=
                                codec_clk_pkg::CLOCK_CONTROL_ADDR;
                            req_reg.wdata <= cfg_core;
                        end
                    end
                end
                codec_clk_pkg::ST_PARAM: begin
                    if (i_dev_done) begin
                        req_reg.wr <= 1'b1;
                        if (idx_reg == 3'(codec_clk_pkg::PARAM_COUNT - 1)) begin
                            state_reg     <= codec_clk_pkg::ST_PLL_ON;
                            req_reg.addr  <=
                                codec_clk_pkg::CLOCK_CONTROL_ADDR;
                            req_reg.wdata <= cfg_pll;
                        end else begin
                            idx_reg       <= idx_reg + 3'h1;
                            req_reg.addr  <= req_reg.addr + 8'h01;
                            req_reg.wdata <= param_reg[idx_reg + 3'h1];
                        end
                    end
                end
                codec_clk_pkg::ST_PLL_ON: begin
                    if (i_dev_done) begin
                        state_reg    <= codec_clk_pkg::ST_POLL_RD;
                        poll_reg     <= 10'h0;
                    end
                end
                // Poll lock status; core stays gated meanwhile
                codec_clk_pkg::ST_POLL_RD: begin
                    state_reg    <= codec_clk_pkg::ST_POLL_WAIT;
                    req_reg.rd   <= 1'b1;
                    req_reg.addr <= codec_clk_pkg::PLL_LOCK_STATUS_ADDR;
                end
                codec_clk_pkg::ST_POLL_WAIT: begin
                    if (i_dev_done && dev_lock) begin
                        state_reg     <= codec_clk_pkg::ST_CORE_ON;
                        locked_reg    <= 1'b1;
                        req_reg.wr    <= 1'b1;
                        req_reg.addr  <= codec_clk_pkg::CLOCK_CONTROL_ADDR;
                        req_reg.wdata <= cfg_core;
                    end else if (i_dev_done) begin
                        poll_reg <= poll_reg + 10'h1;
                        if (poll_reg == 10'(codec_clk_pkg::LOCK_POLL_LIMIT - 1))
                            state_reg <= codec_clk_pkg::ST_FAIL;
                        else
                            state_reg <= codec_clk_pkg::ST_POLL_RD;
                    end
                end
                codec_clk_pkg::ST_CORE_ON: begin
                    if (i_dev_done) begin
                        state_reg  <= codec_clk_pkg::ST_READY;
                        frozen_reg <= 1'b1;
                        ready_reg  <= 1'b1;
                    end
                end
                // Software byte access once core is up, and lock too when the PLL is used
                codec_clk_pkg::ST_READY: begin
                    if (xfer_go_reg) begin
                        xfer_go_reg <= 1'b0;
                        state_reg   <= codec_clk_pkg::ST_XFER;
                    end
                end
                codec_clk_pkg::ST_XFER: begin
                    state_reg    <= codec_clk_pkg::ST_XFER_WAIT;
                    xfer_wr_reg  <= ctrl_reg[2];
                    req_reg.wr   <= ctrl_reg[2];
                    req_reg.rd   <= !ctrl_reg[2];
                    req_reg.addr <= xfer_addr_reg;
                    // Clock control keeps frozen dividers, only source moves
                    req_reg.wdata <= src_only ? cfg_core
                                              : xfer_data_reg;
                    if (ctrl_reg[2] && xfer_addr_reg ==
                        codec_clk_pkg::DSP_RUN_CONTROL_ADDR)
                        dsp_run_reg <= |(xfer_data_reg & dsp_bit);
                end
                codec_clk_pkg::ST_XFER_WAIT: begin
                    if (i_dev_done)
                        state_reg <= codec_clk_pkg::ST_READY;
                end
                codec_clk_pkg::ST_FAIL: begin
                    fail_reg <= 1'b1;
                    if (start)
                        state_reg <= codec_clk_pkg::ST_IDLE;
                end
                default: state_reg <= codec_clk_pkg::ST_IDLE;
            endcase
            // Set after the case so a new go wins over its consume
            if (i_cmd_wr && i_cmd_addr == codec_clk_pkg::CMD_XDATA_ADDR + 4'h1)
                xfer_go_reg <= 1'b1;
        end
    end

    // ****************************************************************
    // Read-back and device port
    // ****************************************************************
    wire [7:0] status_word = {2'b00, refused_reg, dsp_run_reg, fail_reg,
                              frozen_reg, locked_reg, ready_reg};
    wire [7:0] rd_mux =
        (i_cmd_addr == codec_clk_pkg::CMD_CTRL_ADDR)   ? ctrl_reg      :
        (i_cmd_addr == codec_clk_pkg::CMD_CLKCFG_ADDR) ? clkcfg_reg    :
        (i_cmd_addr == codec_clk_pkg::CMD_STATUS_ADDR) ? status_word   :
        (i_cmd_addr == codec_clk_pkg::CMD_XFER_ADDR)   ? xfer_addr_reg :
        (i_cmd_addr == codec_clk_pkg::CMD_XDATA_ADDR)  ? xfer_data_reg :
        (i_cmd_addr >= codec_clk_pkg::CMD_PARAM0_ADDR
         && i_cmd_addr < codec_clk_pkg::CMD_STATUS_ADDR) ? param_reg[pidx] :
        8'h00;

    // Read data stands the cycle after the strobe
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst)
            rdata_reg <= 8'h00;
        else
            rdata_reg <= i_cmd_rd ? rd_mux : 8'h00;
    end

    assign o_cmd_rdata = rdata_reg;
    assign o_dev_wr    = req_reg.wr;
    assign o_dev_rd    = req_reg.rd;
    assign o_dev_addr  = req_reg.addr;
    assign o_dev_wdata = req_reg.wdata;

endmodule

/* testbench/codec_clk_host_chk.sv */
// Checker for the codec clock host: device access order and command port.
// Assumes it is bound to codec_clk_host and sees only that module's ports.
`timescale 1ns/100ps
module codec_clk_host_chk (
    input wire logic       i_sys_clk,
    input wire logic       i_rst,
    input wire logic [3:0] i_cmd_addr,
    input wire logic [7:0] i_cmd_wdata,
    input wire logic       i_cmd_wr,
    input wire logic       i_cmd_rd,
    input wire logic [7:0] o_cmd_rdata,
    input wire logic       o_dev_wr,
    input wire logic       o_dev_rd,
    input wire logic [7:0] o_dev_addr,
    input wire logic [7:0] o_dev_wdata,
    input wire logic       i_dev_done,
    input wire logic [7:0] i_dev_rdata
);
    // ****************************************************************
    // Device port history
    // ****************************************************************
    logic       busy_reg, last_rd_reg, core_reg, lock_reg, pll_reg;
    logic [1:0] div_reg;
    wire req = o_dev_wr || o_dev_rd;
    wire wr0 = o_dev_wr && o_dev_addr == 8'h00;
    wire lock_ans = i_dev_done && last_rd_reg && o_dev_addr == 8'h06
        && i_dev_rdata[0];

    // Outstanding access, enables written and lock reported
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            busy_reg    <= 1'b0;
            last_rd_reg <= 1'b0;
            core_reg    <= 1'b0;
            lock_reg    <= 1'b0;
            pll_reg     <= 1'b0;
            div_reg     <= 2'b00;
        end else begin
            busy_reg <= req || (busy_reg && !i_dev_done);
            if (req) last_rd_reg <= o_dev_rd;
            if (lock_ans) lock_reg <= 1'b1;
            if (wr0) begin
                pll_reg  <= o_dev_wdata[7];
                core_reg <= o_dev_wdata[0];
                if (!o_dev_wdata[7]) lock_reg <= 1'b0;
                if (o_dev_wdata[0] && !core_reg) div_reg <= o_dev_wdata[2:1];
            end
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    sequence s_first_lock;
        lock_ans && !core_reg;
    endsequence
    sequence s_core_write;
        wr0 && o_dev_wdata[0];
    endsequence

    a_rdata_quiet: assert property (!$past(i_cmd_rd) |-> o_cmd_rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_unmapped_zero: assert property ($past(i_cmd_rd)
        && $past(i_cmd_addr) > 4'hA |-> o_cmd_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_strobe_single: assert property (req |=> !req)
        else $error("device strobe longer than one cycle");
    a_one_outstanding: assert property (req |-> !busy_reg && !(o_dev_wr && o_dev_rd))
        else $error("second device access while one is open");
    a_addr_held: assert property (busy_reg |-> $stable(o_dev_addr)
        && $stable(o_dev_wdata)) else $error("device address moved");
    a_lock_window: assert property (req && o_dev_addr > 8'h06
        |-> core_reg && (lock_reg || !pll_reg)) else $error("access past 0x06");
    a_core_locked: assert property (s_core_write ##0 o_dev_wdata[7]
        |-> lock_reg) else $error("core enabled before lock");
    a_params_pll_off: assert property (o_dev_wr
        && o_dev_addr inside {[8'h01:8'h05]} |-> !pll_reg)
        else $error("PLL parameter written with PLL on");
    a_core_follows: assert property (s_first_lock |-> ##[1:8] s_core_write)
        else $error("core not enabled after lock");
    a_div_frozen: assert property (wr0 && core_reg
        |-> o_dev_wdata[2:1] == div_reg) else $error("divider changed");
endmodule

bind codec_clk_host codec_clk_host_chk codec_clk_host_chk_i (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_cmd_addr(i_cmd_addr),
    .i_cmd_wdata(i_cmd_wdata), .i_cmd_wr(i_cmd_wr), .i_cmd_rd(i_cmd_rd),
    .o_cmd_rdata(o_cmd_rdata), .o_dev_wr(o_dev_wr), .o_dev_rd(o_dev_rd),
    .o_dev_addr(o_dev_addr), .o_dev_wdata(o_dev_wdata),
    .i_dev_done(i_dev_done), .i_dev_rdata(i_dev_rdata));

/* testbench/codec_dev_model.sv */
// Behavioural codec device: clock control, PLL registers, lock status.
// Assumes one access at a time from the host; misuse is counted in o_viol.
`timescale 1ns/100ps
module codec_dev_model #(
    parameter int LOCK_CYC = 12,
    parameter int BOOT     = 16
) (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_slow,
    input  wire logic       i_no_lock,
    output logic            o_done,
    output logic      [7:0] o_rdata,
    output logic      [7:0] o_viol
);
    // ****************************************************************
    // Register file, lock timer and access timing
    // ****************************************************************
    logic [7:0] regs [0:15];
    logic [7:0] paddr;
    logic [2:0] wait_cnt;
    logic       pend, pend_rd;
    int         lock_cnt, boot_cnt;
    wire locked = regs[0][7] && !i_no_lock && lock_cnt >= LOCK_CYC;
    wire req    = i_wr || i_rd;
    wire bad    = (req && (pend || boot_cnt < BOOT))
        || (req && i_addr > 8'h06 && !(regs[0][0] && locked))
        || (i_wr && i_addr inside {[8'h01:8'h05]} && regs[0][7])
        || (i_wr && i_addr == 8'h00 && i_wdata[0] && i_wdata[7] && !locked);

    // Store writes at once, answer after a short or long wait
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            regs     <= '{default: 8'h00};
            pend     <= 1'b0;
            pend_rd  <= 1'b0;
            paddr    <= 8'h00;
            wait_cnt <= 3'h0;
            lock_cnt <= 0;
            boot_cnt <= 0;
            o_done   <= 1'b0;
            o_rdata  <= 8'h00;
            o_viol   <= 8'h00;
        end else begin
            if (boot_cnt < BOOT) boot_cnt <= boot_cnt + 1;
            lock_cnt <= regs[0][7] ? lock_cnt + 1 : 0;
            o_done   <= 1'b0;
            o_rdata  <= ~o_rdata; // Released bus keeps moving
            if (bad) o_viol <= o_viol + 8'h01;
            if (i_wr && i_addr != 8'h06 && i_addr < 8'h10) begin
                regs[i_addr[3:0]] <= i_wdata;
            end
            if (req) begin
                pend     <= 1'b1;
                pend_rd  <= i_rd;
                paddr    <= i_addr;
                wait_cnt <= i_slow ? 3'h4 : 3'h0;
            end else if (pend && wait_cnt != 3'h0) begin
                wait_cnt <= wait_cnt - 3'h1;
            end else if (pend) begin
                pend   <= 1'b0;
                o_done <= 1'b1;
                if (pend_rd) begin
                    o_rdata <= paddr == 8'h06 ? {7'h00, locked} : regs[paddr[3:0]];
                end
            end
        end
    end
endmodule

/* testbench/codec_clk_host_tb_top.sv */
// Testbench for the codec clock host against a behavioural device.
// Assumes the checker binds itself to the host; all stimulus starts here.
`timescale 1ns/100ps
module codec_clk_host_tb_top;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       slow = 1'b0;
    logic       no_lock = 1'b0;
    logic [7:0] rdata, dev_addr, dev_wdata, dev_rdata, viol;
    logic       dev_wr, dev_rd, dev_done;
    int         errors = 0;
    int         checks = 0;

    // 100 MHz clock
    always #5 clk = ~clk;

    codec_clk_host #(.RESET_WAIT(20)) codec_clk_host_i (
        .i_sys_clk(clk), .i_rst(rst), .i_cmd_addr(addr), .i_cmd_wdata(wdata),
        .i_cmd_wr(wr), .i_cmd_rd(rd), .o_cmd_rdata(rdata), .o_dev_wr(dev_wr),
        .o_dev_rd(dev_rd), .o_dev_addr(dev_addr), .o_dev_wdata(dev_wdata),
        .i_dev_done(dev_done), .i_dev_rdata(dev_rdata));
    codec_dev_model codec_dev_model_i (
        .i_sys_clk(clk), .i_rst(rst), .i_wr(dev_wr), .i_rd(dev_rd),
        .i_addr(dev_addr), .i_wdata(dev_wdata), .i_slow(slow),
        .i_no_lock(no_lock), .o_done(dev_done), .o_rdata(dev_rdata),
        .o_viol(viol));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cw(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic cr(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    task automatic boot(input logic s, input logic n, input int w);
        @(posedge clk);
        rst     <= 1'b1;
        slow    <= s;
        no_lock <= n;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (w) @(posedge clk);
    endtask
    task automatic wait_st(input int b);
        logic [7:0] s = 8'h00;
        for (int k = 0; k < 4000 && s[b] !== 1'b1; k++) cr(4'h7, s);
    endtask
    task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic w);
        cw(4'h8, a);
        cw(4'h9, d);
        cw(4'h0, w ? 8'h06 : 8'h02);
        cw(4'hA, 8'h00);
        repeat (20) @(posedge clk);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_early;
        logic [7:0] s;
        boot(1'b0, 1'b0, 0);
        cw(4'h0, 8'h01);
        cw(4'hA, 8'h00);
        repeat (30) @(posedge clk);
        cr(4'h7, s);
        chk(s & 8'h21, 8'h20);
        cw(4'h7, 8'h00);
        cr(4'h7, s);
        chk(s & 8'h20, 8'h00);
        cr(4'hF, s);
        chk(s, 8'h00);
        chk(viol, 8'h00);
        $display("test early done");
    endtask
    task automatic t_pll(input logic s, input logic n);
        logic [7:0] p [5];
        logic [7:0] st;
        p = '{8'h00, 8'h7D, 8'h00, 8'h12, 8'h31};
        boot(s, n, 24);
        cw(4'h1, 8'h00);
        for (int k = 0; k < 5; k++) cw(4'(k + 2), p[k]);
        cw(4'h0, 8'h03);
        wait_st(n ? 3 : 0);
        cr(4'h7, st);
        if (n) begin
            chk(st & 8'h0B, 8'h08);
            chk(codec_dev_model_i.regs[0] & 8'h01, 8'h00);
        end else begin
            chk(st & 8'h07, 8'h07);
            chk(codec_dev_model_i.regs[0], 8'h81);
            for (int k = 0; k < 5; k++) chk(codec_dev_model_i.regs[k + 1], p[k]);
        end
        chk(viol, 8'h00);
        $display("test pll done");
    endtask
    task automatic t_live;
        logic [7:0] s;
        cw(4'h1, 8'h0E);
        xfer(8'h06, 8'h00, 1'b0);
        cr(4'h9, s);
        chk(s, 8'h01);
        xfer(8'h09, 8'h01, 1'b1);
        cr(4'h7, s);
        chk(s & 8'h10, 8'h10);
        chk(codec_dev_model_i.regs[9], 8'h01);
        xfer(8'h00, 8'h00, 1'b1);
        chk(codec_dev_model_i.regs[0] & 8'h0F, 8'h09);
        chk(viol, 8'h00);
        $display("test live source done");
    endtask
    task automatic t_bypass;
        logic [7:0] s;
        boot(1'b0, 1'b0, 24);
        cw(4'h1, 8'h06);
        cw(4'h0, 8'h01);
        wait_st(0);
        cr(4'h7, s);
        chk(s & 8'h01, 8'h01);
        chk(codec_dev_model_i.regs[0], 8'h07);
        chk(viol, 8'h00);
        $display("test bypass done");
    endtask

    task automatic conclude;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        t_early;
        t_pll(1'b1, 1'b0);
        t_pll(1'b0, 1'b1);
        t_pll(1'b0, 1'b0);
        t_live;
        t_bypass;
        conclude;
    end

    // Watchdog against a hung handshake
    initial begin
        #600000;
        errors++;
        conclude;
    end
endmodule
